/* common/mdsc_defines.svh */
// Offsets, field positions, reset values and timing counts of the mode and system control block
`ifndef MDSC_DEFINES_SVH
`define MDSC_DEFINES_SVH
`define MDSC_OFS_MODE_STAT   16'hFFF1
`define MDSC_OFS_SYS_CTRL    16'hFFF2
// Bus byte address is four times the register index
`define MDSC_ADDR_MODE_STAT  32'h0003FFC4
`define MDSC_ADDR_SYS_CTRL   32'h0003FFC8
`define MDSC_ADDR_WIDTH      18
`define MDSC_SYSTEM_CONTROL_RESET     8'h0B
`define MDSC_MODE_FIXED      8'hC4
`define MDSC_BIT_STANDBY_SELECT        7
`define MDSC_BIT_STS_HI      6
`define MDSC_BIT_STS_LO      4
`define MDSC_BIT_UE          3
`define MDSC_BIT_NONMASK_EDGE_SELECT       2
`define MDSC_BIT_RO1         1
`define MDSC_BIT_RAM_ENABLE        0
`define MDSC_SETTLE_BASE     18'h02000
`define MDSC_RAM_START       24'hFFFB10
`define MDSC_RAM_END         24'hFFFF0F
`define MDSC_AREA_SHIFT      17
`endif

/* common/mdsc_pkg.sv */
// Types of the mode and system control block
package mdsc_pkg;
  typedef enum logic [3:0] {
    MDSC_IDLE  = 4'h1,
    MDSC_WRITE = 4'h2,
    MDSC_READ  = 4'h4,
    MDSC_DONE  = 4'h8
  } mdsc_phase_e;
  typedef enum logic [1:0] {
    MDSC_MODE_BAD = 2'h0,
    MDSC_MODE_EXP = 2'h1,
    MDSC_MODE_NRM = 2'h2,
    MDSC_MODE_ADV = 2'h3
  } mdsc_mode_e;
endpackage

/* logic/mdsc_settle.sv */
// Settling wait counter used on software standby exit
`include "mdsc_defines.svh"
module mdsc_settle (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        start,
  input  wire logic [2:0]  sel,
  output logic             busy,
  output logic             done
);
  typedef struct packed {
    logic [17:0] cnt;
    logic        busy;
    logic        done;
  } mdsc_settle_s;
  mdsc_settle_s st_r;
  mdsc_settle_s st_nxt;

  function automatic logic [17:0] mdsc_len(input logic [2:0] s);
    case (s)
      3'h0: mdsc_len = `MDSC_SETTLE_BASE;
      3'h1: mdsc_len = 18'(`MDSC_SETTLE_BASE << 1);
      3'h2: mdsc_len = 18'(`MDSC_SETTLE_BASE << 2);
      3'h3: mdsc_len = 18'(`MDSC_SETTLE_BASE << 3);
      3'h4,
      3'h5: mdsc_len = 18'(`MDSC_SETTLE_BASE << 4);
      default: mdsc_len = 18'(`MDSC_SETTLE_BASE << 4);
    endcase
  endfunction

  always_comb begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    if (start && !st_r.busy) begin
      st_nxt.busy = 1'b1;
      st_nxt.cnt = 18'(mdsc_len(sel) - 18'h00001);
    end else if (st_r.busy) begin
      if (st_r.cnt == 18'h00000) begin
        st_nxt.busy = 1'b0;
        st_nxt.done = 1'b1;
      end else begin
        st_nxt.cnt = 18'(st_r.cnt - 18'h00001);
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign busy = st_r.busy;
  assign done = st_r.done;
endmodule

/* logic/mdsc_top.sv */
// Mode status and system control registers behind an AHB-Lite slave
`include "mdsc_defines.svh"
module mdsc_top (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        mode_pin_hi,
  input  wire logic        mode_pin_lo,
  input  wire logic        sleep_req,
  input  wire logic        ext_irq_wake,
  input  wire logic        nmi_in,
  input  wire logic        exc_take,
  input  wire logic [23:0] cpu_addr,
  input  wire logic        cpu_ram_wr,
  input  wire logic [7:0]  ram_rdata,
  input  wire logic [7:0]  port_dir_hi,
  input  wire logic [7:0]  port_dir_mid,
  input  wire logic [3:0]  port_dir_lo,
  output logic             sleep_mode,
  output logic             soft_standby,
  output logic             settle_wait,
  output logic             nmi_req,
  output logic             set_mask_flag,
  output logic             set_user_flag,
  output logic             user_flag_is_mask,
  output logic             ram_active,
  output logic [7:0]       ram_rd_value,
  output logic             ram_wr_allow,
  output logic             ext_bus_en,
  output logic             wide_space,
  output logic             port6_strobes,
  output logic [19:0]      addr_pin_en,
  output logic [2:0]       area_sel
);
  typedef struct packed {
    mdsc_pkg::mdsc_phase_e phase;
    logic [`MDSC_ADDR_WIDTH-1:0] addr;
    logic [31:0] rdata;
    logic [1:0]  mode_latch;
    logic        standby_select;
    logic [2:0]  sts;
    logic        ue;
    logic        nonmask_edge_select;
    logic        ram_enable;
    logic        nmi_prev;
    logic        nmi_req;
    logic        sleep_mode;
    logic        standby;
    logic        settle;
    logic        set_mask;
    logic        set_user;
    logic        ram_active;
    logic [7:0]  ram_rd;
    logic        ram_wr;
    logic        ext_bus;
    logic        wide;
    logic        p6_strobe;
    logic [19:0] addr_en;
    logic [2:0]  area;
    logic        rdy;
    logic        uim;
  } mdsc_state_s;
  mdsc_state_s st_r;
  mdsc_state_s st_nxt;
  logic        settle_busy;
  logic        settle_done;
  logic        settle_start;
  logic        take;
  logic [7:0]  sysctl_view;
  logic [1:0]  mode_now;
  logic        rd_stat;
  logic        rd_sysctl;
  logic        wr_sysctl;

  // Address decode shared by write and read paths
  function automatic logic mdsc_hit(input logic [`MDSC_ADDR_WIDTH-1:0] a,
                                    input logic [31:0] reg_addr);
    mdsc_hit = (a == reg_addr[`MDSC_ADDR_WIDTH-1:0]);
  endfunction

  assign take = hsel && hready && htrans[1];
  assign mode_now = {mode_pin_hi, mode_pin_lo};
  assign sysctl_view = {st_r.standby_select, st_r.sts, st_r.ue, st_r.nonmask_edge_select, 1'b1, st_r.ram_enable};
  assign settle_start = st_r.standby && ext_irq_wake;

  mdsc_settle u_settle (
    .hclk    (hclk),
    .hresetn (hresetn),
    .start   (settle_start),
    .sel     (st_r.sts),
    .busy    (settle_busy),
    .done    (settle_done)
  );

  always_comb begin
    st_nxt = st_r;
    // Bus slave: every access takes one wait cycle so read data come from a flop
    case (st_r.phase)
      mdsc_pkg::MDSC_IDLE: begin
        if (take) begin
          st_nxt.addr = haddr[`MDSC_ADDR_WIDTH-1:0];
          st_nxt.phase = hwrite ? mdsc_pkg::MDSC_WRITE : mdsc_pkg::MDSC_READ;
        end
      end
      mdsc_pkg::MDSC_WRITE: begin
        // Writes to the mode status word fall through untouched
        if (mdsc_hit(st_r.addr, `MDSC_ADDR_SYS_CTRL)) begin
          st_nxt.standby_select  = hwdata[`MDSC_BIT_STANDBY_SELECT];
          st_nxt.sts   = hwdata[`MDSC_BIT_STS_HI:`MDSC_BIT_STS_LO];
          st_nxt.ue    = hwdata[`MDSC_BIT_UE];
          st_nxt.nonmask_edge_select = hwdata[`MDSC_BIT_NONMASK_EDGE_SELECT];
          st_nxt.ram_enable  = hwdata[`MDSC_BIT_RAM_ENABLE];
        end
        st_nxt.phase = mdsc_pkg::MDSC_DONE;
      end
      mdsc_pkg::MDSC_READ: begin
        st_nxt.rdata = 32'h00000000;
        if (mdsc_hit(st_r.addr, `MDSC_ADDR_MODE_STAT)) begin
          st_nxt.mode_latch = mode_now;
          st_nxt.rdata = {24'h000000, `MDSC_MODE_FIXED | {6'h00, mode_now}};
        end else if (mdsc_hit(st_r.addr, `MDSC_ADDR_SYS_CTRL)) begin
          st_nxt.rdata = {24'h000000, sysctl_view};
        end
        st_nxt.phase = mdsc_pkg::MDSC_DONE;
      end
      mdsc_pkg::MDSC_DONE: begin
        st_nxt.phase = mdsc_pkg::MDSC_IDLE;
        if (take) begin
          st_nxt.addr = haddr[`MDSC_ADDR_WIDTH-1:0];
          st_nxt.phase = hwrite ? mdsc_pkg::MDSC_WRITE : mdsc_pkg::MDSC_READ;
        end
      end
      default: st_nxt.phase = mdsc_pkg::MDSC_IDLE;
    endcase

    // Power-down selection; standby select is never cleared by wake-up
    st_nxt.sleep_mode = 1'b0;
    if (sleep_req && !st_r.standby && !st_r.sleep_mode) begin
      if (st_r.standby_select) begin
        st_nxt.standby = 1'b1;
      end else begin
        st_nxt.sleep_mode = 1'b1;
      end
    end
    if (settle_start) begin
      st_nxt.standby = 1'b0;
    end
    st_nxt.settle = settle_busy && !settle_done;

    // Nonmaskable edge detection
    st_nxt.nmi_prev = nmi_in;
    st_nxt.nmi_req = st_r.nonmask_edge_select ? (nmi_in && !st_r.nmi_prev)
                                : (!nmi_in && st_r.nmi_prev);

    // Exception entry flags for the CPU
    st_nxt.set_mask = exc_take;
    st_nxt.set_user = exc_take && !st_r.ue;

    // Mode decode; pins assumed steady while running
    st_nxt.ext_bus = (mode_now == mdsc_pkg::MDSC_MODE_EXP);
    st_nxt.wide = (mode_now != mdsc_pkg::MDSC_MODE_NRM);
    st_nxt.p6_strobe = (mode_now == mdsc_pkg::MDSC_MODE_EXP);
    st_nxt.addr_en = (mode_now == mdsc_pkg::MDSC_MODE_EXP)
                   ? {port_dir_lo, port_dir_mid, port_dir_hi} : 20'h00000;
    st_nxt.area = cpu_addr[`MDSC_AREA_SHIFT+2:`MDSC_AREA_SHIFT];

    // On-chip RAM gating; in every mode a disabled RAM reads as 8'hFF and takes no writes
    st_nxt.ram_active = st_r.ram_enable && (cpu_addr >= `MDSC_RAM_START)
                        && (cpu_addr <= `MDSC_RAM_END);
    st_nxt.ram_rd = st_r.ram_enable ? ram_rdata : 8'hFF;
    st_nxt.ram_wr = cpu_ram_wr && st_r.ram_enable;

    // Ready and mask view are registered so every output but the constant hresp leaves a flop
    st_nxt.rdy = (st_nxt.phase != mdsc_pkg::MDSC_WRITE)
                 && (st_nxt.phase != mdsc_pkg::MDSC_READ);
    st_nxt.uim = !st_nxt.ue;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= '0;
      st_r.phase <= mdsc_pkg::MDSC_IDLE;
      st_r.ue <= 1'b1;
      st_r.ram_enable <= 1'b1;
      st_r.nmi_prev <= 1'b1;
      st_r.rdy <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign hrdata = st_r.rdata;
  assign hreadyout = st_r.rdy;
  assign hresp = 1'b0;
  assign sleep_mode = st_r.sleep_mode;
  assign soft_standby = st_r.standby;
  assign settle_wait = st_r.settle;
  assign nmi_req = st_r.nmi_req;
  assign set_mask_flag = st_r.set_mask;
  assign set_user_flag = st_r.set_user;
  assign user_flag_is_mask = st_r.uim;
  assign ram_active = st_r.ram_active;
  assign ram_rd_value = st_r.ram_rd;
  assign ram_wr_allow = st_r.ram_wr;
  assign ext_bus_en = st_r.ext_bus;
  assign wide_space = st_r.wide;
  assign port6_strobes = st_r.p6_strobe;
  assign addr_pin_en = st_r.addr_en;
  assign area_sel = st_r.area;

  a_mode_read_val: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_r.phase == mdsc_pkg::MDSC_READ && mdsc_hit(st_r.addr, `MDSC_ADDR_MODE_STAT))
    |=> hrdata[7:2] == 6'h31)
    else $error("mode status fixed bits wrong");
  a_mode_pins_seen: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_r.phase == mdsc_pkg::MDSC_READ && mdsc_hit(st_r.addr, `MDSC_ADDR_MODE_STAT))
    |=> hrdata[1:0] == $past(mode_now))
    else $error("mode pins not reported");
  a_sysctl_ro_one: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_r.phase == mdsc_pkg::MDSC_READ && mdsc_hit(st_r.addr, `MDSC_ADDR_SYS_CTRL))
    |=> hrdata[1])
    else $error("system control bit 1 not one");
  a_standby_choice: assert property (@(posedge hclk) disable iff (!hresetn)
    (sleep_req && !st_r.standby && !st_r.sleep_mode && st_r.standby_select) |=> soft_standby)
    else $error("standby not entered");
  a_standby_select_kept: assert property (@(posedge hclk) disable iff (!hresetn)
    (settle_start && st_r.phase != mdsc_pkg::MDSC_WRITE) |=> st_r.standby_select == $past(st_r.standby_select))
    else $error("standby select changed on wake");
  a_nmi_edge: assert property (@(posedge hclk) disable iff (!hresetn)
    (!st_r.nonmask_edge_select && $fell(nmi_in) && $stable(st_r.nonmask_edge_select)) |=> nmi_req)
    else $error("falling edge missed");
  a_user_flag_set: assert property (@(posedge hclk) disable iff (!hresetn)
    (exc_take && !st_r.ue) |=> set_user_flag && set_mask_flag)
    else $error("user flag not set");
  a_ram_off_ff: assert property (@(posedge hclk) disable iff (!hresetn)
    !st_r.ram_enable |=> ram_rd_value == 8'hFF && !ram_wr_allow)
    else $error("disabled RAM not blocked");
  a_bus_wait: assert property (@(posedge hclk) disable iff (!hresetn)
    (take && st_r.phase != mdsc_pkg::MDSC_WRITE && st_r.phase != mdsc_pkg::MDSC_READ)
    |=> !hreadyout ##1 hreadyout)
    else $error("wait cycle wrong");

  // Bus-side views for the checks below
  assign rd_stat   = (st_r.phase == mdsc_pkg::MDSC_READ)
                     && mdsc_hit(st_r.addr, `MDSC_ADDR_MODE_STAT);
  assign rd_sysctl = (st_r.phase == mdsc_pkg::MDSC_READ)
                     && mdsc_hit(st_r.addr, `MDSC_ADDR_SYS_CTRL);
  assign wr_sysctl = (st_r.phase == mdsc_pkg::MDSC_WRITE)
                     && mdsc_hit(st_r.addr, `MDSC_ADDR_SYS_CTRL);

  a_mode_zero_bits: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_stat |=> hrdata[5:3] == 3'h0)
    else $error("mode status reserved zeros wrong");
  a_read_upper: assert property (@(posedge hclk) disable iff (!hresetn)
    st_r.phase == mdsc_pkg::MDSC_READ |=> hrdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  a_read_unmapped: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_r.phase == mdsc_pkg::MDSC_READ && !rd_stat && !rd_sysctl) |=> hrdata == 32'h00000000)
    else $error("unmapped read not zero");
  a_hrdata_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    st_r.phase != mdsc_pkg::MDSC_READ |=> $stable(hrdata))
    else $error("read data moved without a read");
  a_wait_once: assert property (@(posedge hclk) disable iff (!hresetn)
    !hreadyout |=> hreadyout)
    else $error("wait state longer than one cycle");
  a_stat_write_none: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_r.phase == mdsc_pkg::MDSC_WRITE && !wr_sysctl)
    |=> $stable({st_r.standby_select, st_r.sts, st_r.ue, st_r.nonmask_edge_select, st_r.ram_enable}))
    else $error("other write changed control bits");
  a_sysctl_update: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_sysctl |=> {st_r.standby_select, st_r.sts} == $past(hwdata[7:4]))
    else $error("standby fields not written");
  a_user_mask_view: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_sysctl |=> user_flag_is_mask == !$past(hwdata[3]))
    else $error("user flag role wrong");
  a_ram_enable_kept: assert property (@(posedge hclk) disable iff (!hresetn)
    st_r.phase != mdsc_pkg::MDSC_WRITE |=> $stable(st_r.ram_enable))
    else $error("RAM enable moved without a write");

  // Power-down, interrupt edge and exception checks
  a_sleep_choice: assert property (@(posedge hclk) disable iff (!hresetn)
    (sleep_req && !st_r.standby && !st_r.sleep_mode && !st_r.standby_select)
    |=> sleep_mode && !soft_standby)
    else $error("sleep not entered");
  a_sleep_pulse: assert property (@(posedge hclk) disable iff (!hresetn)
    sleep_mode |=> !sleep_mode)
    else $error("sleep indication longer than one cycle");
  a_standby_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    (soft_standby && !ext_irq_wake) |=> soft_standby)
    else $error("standby left without a wake");
  a_settle_go: assert property (@(posedge hclk) disable iff (!hresetn)
    (settle_start && !settle_busy) |=> settle_busy && !soft_standby)
    else $error("settle wait not started");
  a_nmi_rise: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_r.nonmask_edge_select && $rose(nmi_in) && $stable(st_r.nonmask_edge_select)) |=> nmi_req)
    else $error("rising edge missed");
  a_nmi_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
    (nmi_in == st_r.nmi_prev) |=> !nmi_req)
    else $error("request without an edge");
  a_mask_only: assert property (@(posedge hclk) disable iff (!hresetn)
    (exc_take && st_r.ue) |=> set_mask_flag && !set_user_flag)
    else $error("user flag set while it is a user bit");
  a_no_exc_flags: assert property (@(posedge hclk) disable iff (!hresetn)
    !exc_take |=> !set_mask_flag && !set_user_flag)
    else $error("flag set without an exception");

  // RAM gating, mode decode and area select checks
  a_ram_on_pass: assert property (@(posedge hclk) disable iff (!hresetn)
    st_r.ram_enable |=> ram_rd_value == $past(ram_rdata) && ram_wr_allow == $past(cpu_ram_wr))
    else $error("enabled RAM not passed through");
  a_ram_range: assert property (@(posedge hclk) disable iff (!hresetn)
    (cpu_addr < `MDSC_RAM_START || cpu_addr > `MDSC_RAM_END) |=> !ram_active)
    else $error("RAM active outside its range");
  a_exp_decode: assert property (@(posedge hclk) disable iff (!hresetn)
    (mode_now == mdsc_pkg::MDSC_MODE_EXP) |=> ext_bus_en && wide_space && port6_strobes)
    else $error("expanded mode decode wrong");
  a_addr_pins: assert property (@(posedge hclk) disable iff (!hresetn)
    (mode_now == mdsc_pkg::MDSC_MODE_EXP)
    |=> addr_pin_en == $past({port_dir_lo, port_dir_mid, port_dir_hi}))
    else $error("address pins do not follow direction bits");
  a_single_chip: assert property (@(posedge hclk) disable iff (!hresetn)
    (mode_now != mdsc_pkg::MDSC_MODE_EXP)
    |=> !ext_bus_en && !port6_strobes && addr_pin_en == 20'h00000)
    else $error("single chip mode drives external pins");
  a_normal_narrow: assert property (@(posedge hclk) disable iff (!hresetn)
    (mode_now == mdsc_pkg::MDSC_MODE_NRM) |=> !wide_space)
    else $error("normal mode space too wide");
  a_adv_wide: assert property (@(posedge hclk) disable iff (!hresetn)
    (mode_now == mdsc_pkg::MDSC_MODE_ADV) |=> wide_space && !ext_bus_en)
    else $error("advanced mode decode wrong");
  a_area_pick: assert property (@(posedge hclk) disable iff (!hresetn)
    1'b1 |=> area_sel == $past(cpu_addr[`MDSC_AREA_SHIFT+2:`MDSC_AREA_SHIFT]))
    else $error("area select wrong");

  c_sys_write: cover property (@(posedge hclk) disable iff (!hresetn)
    st_r.phase == mdsc_pkg::MDSC_WRITE && mdsc_hit(st_r.addr, `MDSC_ADDR_SYS_CTRL));
  c_mode_read: cover property (@(posedge hclk) disable iff (!hresetn)
    st_r.phase == mdsc_pkg::MDSC_READ && mdsc_hit(st_r.addr, `MDSC_ADDR_MODE_STAT));
  c_standby_wake: cover property (@(posedge hclk) disable iff (!hresetn) settle_done);
  c_sleep_entry: cover property (@(posedge hclk) disable iff (!hresetn) sleep_mode);
  c_nmi_seen: cover property (@(posedge hclk) disable iff (!hresetn) nmi_req);
endmodule

/* test/mdsc_testbench.sv */
// Self-checking bench for the mode and system control registers
`include "mdsc_defines.svh"
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic        mode_pin_hi = 1'b1;
  logic        mode_pin_lo = 1'b0;
  logic        sleep_req = 1'b0;
  logic        ext_irq_wake = 1'b0;
  logic        nmi_in = 1'b1;
  logic        exc_take = 1'b0;
  logic [23:0] cpu_addr = 24'hFFFC00;
  logic        cpu_ram_wr = 1'b1;
  logic [7:0]  ram_rdata = 8'h5A;
  logic [7:0]  port_dir_hi = 8'h0;
  logic [7:0]  port_dir_mid = 8'h0;
  logic [3:0]  port_dir_lo = 4'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        sleep_mode, soft_standby, settle_wait, nmi_req, set_mask_flag, set_user_flag;
  logic        user_flag_is_mask, ram_active, ram_wr_allow, ext_bus_en, wide_space;
  logic        port6_strobes;
  logic [7:0]  ram_rd_value;
  logic [19:0] addr_pin_en;
  logic [2:0]  area_sel;
  int          n_mismatch = 0;
  int          tests_run = 0;
  int          cycles = 0;
  int          n_nmi = 0, n_sleep = 0, n_mask = 0, n_user = 0, n_settle = 0;
  int          c0, c1;
  mdsc_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .mode_pin_hi(mode_pin_hi),
    .mode_pin_lo(mode_pin_lo), .sleep_req(sleep_req), .ext_irq_wake(ext_irq_wake),
    .nmi_in(nmi_in), .exc_take(exc_take), .cpu_addr(cpu_addr), .cpu_ram_wr(cpu_ram_wr),
    .ram_rdata(ram_rdata), .port_dir_hi(port_dir_hi), .port_dir_mid(port_dir_mid),
    .port_dir_lo(port_dir_lo), .sleep_mode(sleep_mode), .soft_standby(soft_standby),
    .settle_wait(settle_wait), .nmi_req(nmi_req), .set_mask_flag(set_mask_flag),
    .set_user_flag(set_user_flag), .user_flag_is_mask(user_flag_is_mask),
    .ram_active(ram_active), .ram_rd_value(ram_rd_value), .ram_wr_allow(ram_wr_allow),
    .ext_bus_en(ext_bus_en), .wide_space(wide_space), .port6_strobes(port6_strobes),
    .addr_pin_en(addr_pin_en), .area_sel(area_sel));
  initial begin
    forever #2.5 hclk = ~hclk;
  end
  // Pulse outputs are counted so a test can compare counts before and after
  always @(posedge hclk) begin
    cycles++;
    if (nmi_req === 1'b1) n_nmi++;
    if (sleep_mode === 1'b1) n_sleep++;
    if (set_mask_flag === 1'b1) n_mask++;
    if (set_user_flag === 1'b1) n_user++;
    if (settle_wait === 1'b1) n_settle++;
    if (cycles == 40000) begin
      n_mismatch++;
      conclude();
    end
  end
  task automatic conclude();
    $display("TB: checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      n_mismatch++;
    end
  endtask
  // Ready is judged at the negedge before each edge, as the slave's flop holds it there
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    logic rdy;
    @(posedge hclk);
    hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= w; hsize <= 3'h2;
    do begin
      @(negedge hclk); rdy = hreadyout; @(posedge hclk);
    end while (rdy !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    do begin
      @(negedge hclk); rdy = hreadyout; r = hrdata; @(posedge hclk);
    end while (rdy !== 1'b1);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    chk(r, exp);
    chk(hresp, 1'b0);
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge hclk);
    @(negedge hclk);
  endtask
  task automatic pulse(input int k);
    @(posedge hclk);
    case (k)
      0: sleep_req <= 1'b1;
      1: ext_irq_wake <= 1'b1;
      default: exc_take <= 1'b1;
    endcase
    @(posedge hclk);
    sleep_req <= 1'b0; ext_irq_wake <= 1'b0; exc_take <= 1'b0;
    idle(3);
  endtask
  task automatic nmi_to(input logic v);
    @(posedge hclk);
    nmi_in <= v;
    idle(3);
  endtask
  // Mode pins change only while reset is held, as the board may not move them in operation
  task automatic do_reset(input logic [1:0] m);
    @(posedge hclk);
    hresetn <= 1'b0;
    {mode_pin_hi, mode_pin_lo} <= m;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    idle(1);
  endtask
  // Short settle codes keep the run brief; firmware must pick a wait of 8 ms or more
  task automatic standby(input logic [31:0] v, input int n);
    wr(`MDSC_ADDR_SYS_CTRL, v);
    c1 = n_sleep;
    pulse(0);
    chk(soft_standby, 1'b1);
    chk(n_sleep - c1, 0);
    c0 = n_settle;
    pulse(1);
    idle(n + 8);
    chk(n_settle - c0, n);
    chk(soft_standby, 1'b0);
    rd(`MDSC_ADDR_SYS_CTRL, v);
  endtask
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    idle(1);
    rd(`MDSC_ADDR_SYS_CTRL, 32'h0B);
    rd(`MDSC_ADDR_MODE_STAT, 32'hC6);
    wr(`MDSC_ADDR_MODE_STAT, 32'hFF);
    rd(`MDSC_ADDR_MODE_STAT, 32'hC6);
    rd(32'h0000FFCC, 32'h0);
    rd(32'h0000FFC8, 32'h0);
    chk({ext_bus_en, wide_space, port6_strobes, addr_pin_en}, 23'h0);
    c0 = n_nmi;
    nmi_to(1'b0);
    chk(n_nmi - c0, 1);
    nmi_to(1'b1);
    chk(n_nmi - c0, 1);
    wr(`MDSC_ADDR_SYS_CTRL, 32'h0F);
    nmi_to(1'b0);
    chk(n_nmi - c0, 1);
    nmi_to(1'b1);
    chk(n_nmi - c0, 2);
    c0 = n_mask;
    c1 = n_user;
    pulse(2);
    chk(user_flag_is_mask, 1'b0);
    chk(n_mask - c0, 1);
    chk(n_user - c1, 0);
    wr(`MDSC_ADDR_SYS_CTRL, 32'h07);
    pulse(2);
    chk(user_flag_is_mask, 1'b1);
    chk(n_mask - c0, 2);
    chk(n_user - c1, 1);
    chk({ram_active, ram_wr_allow, ram_rd_value, area_sel}, {2'h3, 8'h5A, 3'h7});
    wr(`MDSC_ADDR_SYS_CTRL, 32'h00);
    rd(`MDSC_ADDR_SYS_CTRL, 32'h02);
    @(posedge hclk);
    cpu_addr <= 24'hFFFF0F;
    idle(2);
    chk({ram_active, ram_wr_allow, ram_rd_value}, {2'h0, 8'hFF});
    @(posedge hclk);
    cpu_addr <= 24'h0A0000;
    idle(2);
    chk(area_sel, 3'h5);
    standby(32'h8B, 8192);
    standby(32'h9A, 16384);
    wr(`MDSC_ADDR_SYS_CTRL, 32'h0B);
    c1 = n_sleep;
    pulse(0);
    chk(n_sleep - c1, 1);
    chk(soft_standby, 1'b0);
    do_reset(2'h1);
    rd(`MDSC_ADDR_SYS_CTRL, 32'h0B);
    rd(`MDSC_ADDR_MODE_STAT, 32'hC5);
    chk({ext_bus_en, wide_space, port6_strobes, addr_pin_en}, {3'h7, 20'h0});
    @(posedge hclk);
    port_dir_hi <= 8'hA5; port_dir_mid <= 8'h3C; port_dir_lo <= 4'h9;
    idle(2);
    chk(addr_pin_en, 20'h93CA5);
    do_reset(2'h3);
    rd(`MDSC_ADDR_MODE_STAT, 32'hC7);
    chk({ext_bus_en, wide_space, port6_strobes, addr_pin_en}, {3'h2, 20'h0});
    conclude();
  end
endmodule
